//--- src/window_watchdog_supervisor.sv
// supervisor: latched surge fault, supply hold, window watchdog
module window_watchdog_supervisor
  import wwdt_pkg::*;
#(
  parameter int unsigned WIN_SEL_DEFAULT = 3,   // option index 0..12
  parameter int unsigned HOLD_SEL_DEFAULT = 2   // option index 0..14
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rail_over,        // comparator: rail above upper threshold
  input wire logic rail_under,       // comparator: rail below lower threshold
  input wire logic fault_wipe_n,     // active-low latch clear
  input wire logic kick_input,       // watchdog kick from host
  input wire logic [OPT_W-1:0] win_sel,   // window option, 0..12
  input wire logic [OPT_W-1:0] hold_sel,  // hold option, 0..14
  output logic surge_fault_latch_n,  // open-drain output level
  output logic surge_fault_oe,       // high while pulling low
  output logic supply_hold_n,
  output logic supply_hold_oe,
  output logic kick_fault_n,
  output logic kick_fault_oe
);
  // refuse fallback options that the tables do not hold
  if (WIN_SEL_DEFAULT >= WIN_OPTIONS) begin : g_bad_win
    $error("bad window option");
  end
  if (HOLD_SEL_DEFAULT >= HOLD_OPTIONS) begin : g_bad_hold
    $error("bad hold option");
  end

  // reset release through two flops
  logic rs1_q, rs2_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire srst_n = rs2_q;

  // thresholds are placed symmetrically upstream; both arrive as levels
  wire rail_out = rail_over | rail_under;

  // out-of-range selects fall back to the defaults
  wire [OPT_W-1:0] win_idx = (win_sel < OPT_W'(WIN_OPTIONS)) ? win_sel
                             : OPT_W'(WIN_SEL_DEFAULT);
  wire [OPT_W-1:0] hold_idx = (hold_sel < OPT_W'(HOLD_OPTIONS)) ? hold_sel
                              : OPT_W'(HOLD_SEL_DEFAULT);

  // early limit doubles per option, late is tenfold
  wire [CNT_W-1:0] early_limit = CNT_W'(CYC_PER_MS) << win_idx;
  wire [CNT_W-1:0] late_limit = CNT_W'(early_limit * LATE_FACTOR);

  // hold time lookup, one entry per option
  logic [CNT_W-1:0] hold_tab [HOLD_OPTIONS];
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_OPTIONS; gi++) begin : g_hold
      assign hold_tab[gi] = CNT_W'(64'(HOLD_MS[gi]) * 64'(CYC_PER_MS));
    end
  endgenerate
  wire [CNT_W-1:0] reset_hold_time = hold_tab[hold_idx];

  // overvoltage persistence counter; 10 bits since 500 cycles overflow a byte
  logic [9:0] ov_cnt_q;
  wire ov_qual = rail_over && (ov_cnt_q == 10'(FAULT_DELAY_CYC - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ov_cnt_q <= 10'h000;
    end else if (!srst_n || !rail_over) begin
      ov_cnt_q <= 10'h000;        // glitch below the delay restarts it
    end else if (!ov_qual) begin
      ov_cnt_q <= ov_cnt_q + 10'h001;
    end
  end

  // wipe low-time counter, saturating just past the limit
  logic [9:0] wipe_cnt_q;
  wire wipe_long = (wipe_cnt_q >= 10'(WIPE_PULSE_CYC));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wipe_cnt_q <= 10'h000;
    end else if (!srst_n || fault_wipe_n) begin
      wipe_cnt_q <= 10'h000;
    end else if (!wipe_long) begin
      wipe_cnt_q <= wipe_cnt_q + 10'h001;
    end
  end
  wire wipe_hit = (wipe_cnt_q == 10'(WIPE_PULSE_CYC - 1)) && !fault_wipe_n;

  // surge latch: set wins, wipe ignored during overvoltage
  logic surge_q;
  wire surge_set = ov_qual;
  wire surge_clr = wipe_hit && !rail_over;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      surge_q <= 1'b0;
    end else if (!srst_n) begin
      surge_q <= 1'b0;
    end else if (surge_set) begin
      surge_q <= 1'b1;
    end else if (surge_clr) begin
      surge_q <= 1'b0;
    end
  end

  // supply hold: low while out of window or long wipe, then hold time
  wire hold_cause = rail_out || wipe_long;
  wire hold_busy;
  logic hold_low_q;
  logic hold_cause_q;
  // reload at the end of the cause, count hold time afterwards
  wire hold_load = hold_cause_q && !hold_cause;
  window_timer #(.WIDTH(CNT_W)) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .load(hold_load),
    .load_val(reset_hold_time),
    .busy(hold_busy),
    .done()
  );
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_cause_q <= 1'b1;       // reset counts as a cause, so the hold time runs after it
      hold_low_q <= 1'b1;         // held in reset from power-up
    end else if (!srst_n) begin
      hold_cause_q <= 1'b1;
      hold_low_q <= 1'b1;
    end else begin
      hold_cause_q <= hold_cause;
      if (hold_cause) begin
        hold_low_q <= 1'b1;
      end else if (!hold_load && !hold_busy && !hold_cause_q) begin
        hold_low_q <= 1'b0;
      end
    end
  end
  // a long wipe issued too soon only restarts the hold; host keeps spacing
  wire hold_release = hold_low_q && !hold_cause && !hold_load && !hold_busy
                      && !hold_cause_q;

  // kick falling-edge detect
  logic kick_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kick_q <= 1'b1;
    end else begin
      kick_q <= kick_input;
    end
  end
  wire kick_fall = kick_q && !kick_input;   // host kicks per window

  // interval timer counts up from the last kick
  logic [CNT_W-1:0] ivl_q;
  logic armed_q;          // set the cycle after release, so timing runs from the release
  wire fault_busy;
  wire wd_run = !hold_low_q && !fault_busy;
  wire too_early = kick_fall && armed_q && (ivl_q < early_limit);
  wire too_late = kick_fall && armed_q && (ivl_q > late_limit);
  wire timeout = wd_run && !kick_fall && (ivl_q >= late_limit);
  wire start_short = wd_run && too_early;
  wire start_long = wd_run && (too_late || timeout);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ivl_q <= '0;
      armed_q <= 1'b0;
    end else if (!srst_n || hold_low_q || hold_release) begin
      ivl_q <= '0;
      armed_q <= 1'b0;
    end else if (fault_busy || start_long || start_short) begin
      ivl_q <= '0;
      armed_q <= 1'b0;
    end else if (kick_fall) begin
      ivl_q <= '0;
      armed_q <= 1'b1;
    end else begin
      ivl_q <= ivl_q + 1'b1;
      armed_q <= armed_q | (ivl_q == '0);
    end
  end

  // kick fault pulse timer
  wire [CNT_W-1:0] fault_len = start_short ? CNT_W'(SHORT_FAULT_MS * CYC_PER_MS)
                                           : CNT_W'(LONG_FAULT_MS * CYC_PER_MS);
  window_timer #(.WIDTH(CNT_W)) u_fault (
    .clock(clock),
    .rst_n(rst_n),
    .load(start_short || start_long),
    .load_val(fault_len),
    .busy(fault_busy),
    .done()
  );

  // output registers, open-drain style
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      surge_fault_latch_n <= 1'b1;
      supply_hold_n <= 1'b0;
      kick_fault_n <= 1'b1;
    end else begin
      surge_fault_latch_n <= ~surge_q;
      supply_hold_n <= ~hold_low_q;
      kick_fault_n <= ~fault_busy;  // deasserted in window
    end
  end
  assign surge_fault_oe = ~surge_fault_latch_n;
  assign supply_hold_oe = ~supply_hold_n;
  assign kick_fault_oe = ~kick_fault_n;
endmodule

//--- src/wwdt_pkg.sv
package wwdt_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;        // system clock rate
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned FAULT_DELAY_US = 5;          // overvoltage fault delay
  localparam int unsigned WIPE_PULSE_US = 5;           // wipe pulse width limit
  localparam int unsigned FAULT_DELAY_CYC = FAULT_DELAY_US * CYC_PER_US;
  localparam int unsigned WIPE_PULSE_CYC = WIPE_PULSE_US * CYC_PER_US;
  localparam int unsigned SHORT_FAULT_MS = 50;         // early kick fault pulse
  localparam int unsigned LONG_FAULT_MS = 100;         // late kick fault pulse
  localparam int unsigned LATE_FACTOR = 10;            // late limit over early limit
  localparam int unsigned WIN_OPTIONS = 13;            // watchdog window options
  localparam int unsigned HOLD_OPTIONS = 15;           // reset hold options
  localparam int unsigned OPT_W = 4;                   // option select width
  localparam logic [OPT_W-1:0] WIN_SEL_RST = 4'h3;     // plain default: 8/80 ms
  localparam logic [OPT_W-1:0] HOLD_SEL_RST = 4'h2;    // plain default: 10 ms
  localparam int unsigned CNT_W = 33;                  // wide enough for 40960 ms
  // reset hold options in ms, index 0 is option 1
  localparam int unsigned HOLD_MS [HOLD_OPTIONS] = '{1, 5, 10, 15, 20, 50, 100, 150,
                                                     200, 250, 300, 500, 750, 1000, 1500};
endpackage

//--- src/window_timer.sv
// one-shot down-counter used for the hold time and the kick fault pulse
module window_timer
  import wwdt_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire at_one = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});

  // refuse a counter too narrow to count down
  if (WIDTH < 2) begin : g_bad_width
    $error("window_timer width too small");
  end

  // load wins over a running count
  assign cnt_d = load ? load_val : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;

  // count register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = at_one & ~load;   // one-cycle pulse as count expires
endmodule

//--- test/wwdt_checker_properties.sv
// port-level checks for the supervisor; counters track input history and the kick fault low time
module wwdt_checker
  import wwdt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rail_over,
  input wire logic rail_under,
  input wire logic fault_wipe_n,
  input wire logic kick_input,
  input wire logic [OPT_W-1:0] win_sel,
  input wire logic [OPT_W-1:0] hold_sel,
  input wire logic surge_fault_latch_n,
  input wire logic surge_fault_oe,
  input wire logic supply_hold_n,
  input wire logic supply_hold_oe,
  input wire logic kick_fault_n,
  input wire logic kick_fault_oe
);
  localparam int unsigned S = SHORT_FAULT_MS * CYC_PER_MS;  // early fault width
  localparam int unsigned L = LONG_FAULT_MS * CYC_PER_MS;   // late fault width
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] over_q, wipe_q, ok_q, low_q;  // consecutive-cycle counters
  logic [31:0] hold_cyc;                     // selected hold time in cycles
  assign hold_cyc = (hold_sel < 4'hf ? HOLD_MS[hold_sel] : HOLD_MS[2]) * CYC_PER_MS;
  // ok_q restarts on rail_over, rail_under or a long wipe, so a short glitch cannot fake an early release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      over_q <= '0;
      wipe_q <= '0;
      ok_q <= '0;
      low_q <= '0;
    end else begin
      over_q <= rail_over ? over_q + 1 : '0;
      wipe_q <= !fault_wipe_n ? wipe_q + 1 : '0;
      ok_q <= (rail_over || rail_under || wipe_q >= 499) ? '0 : ok_q + 1;
      low_q <= !kick_fault_n ? low_q + 1 : '0;
    end
  end
  a_surge_needs_delay: assert property ($fell(surge_fault_latch_n) |-> $past(over_q) >= 499)
    else $error("surge fault came too early");
  a_surge_sets: assert property (over_q == 505 |-> !surge_fault_latch_n)
    else $error("surge fault missing");
  a_wipe_clears: assert property ($rose(surge_fault_latch_n) |-> $past(wipe_q) >= 499)
    else $error("surge fault cleared without long wipe");
  a_wipe_ignored: assert property ($rose(surge_fault_latch_n) |-> !$past(rail_over))
    else $error("surge fault cleared during overvoltage");
  a_wipe_holds: assert property (wipe_q == 505 |-> !supply_hold_n)
    else $error("long wipe did not hold supply");
  a_rail_holds: assert property ((rail_over || rail_under) |-> ##[1:3] !supply_hold_n)
    else $error("rail outside window without hold");
  a_hold_min: assert property ($rose(supply_hold_n) |-> ok_q >= hold_cyc)
    else $error("supply hold released early");
  a_hold_release: assert property (ok_q == hold_cyc + 10 |-> supply_hold_n)
    else $error("supply hold not released");
  a_fault_width: assert property ($rose(kick_fault_n) |->
    (low_q >= S - 3 && low_q <= S + 3) || (low_q >= L - 3 && low_q <= L + 3))
    else $error("kick fault pulse width wrong");
  a_oe_tracks: assert property ((surge_fault_oe == !surge_fault_latch_n) && (supply_hold_oe == !supply_hold_n) && (kick_fault_oe == !kick_fault_n))
    else $error("output enable does not track pin level");
  c_surge: cover property ($fell(surge_fault_latch_n));
  c_kick: cover property ($fell(kick_fault_n));
  c_hold: cover property ($rose(supply_hold_n));
endmodule
bind window_watchdog_supervisor wwdt_checker u_wwdt_checker (.clock(clock), .rst_n(rst_n),
  .rail_over(rail_over), .rail_under(rail_under), .fault_wipe_n(fault_wipe_n),
  .kick_input(kick_input), .win_sel(win_sel), .hold_sel(hold_sel),
  .surge_fault_latch_n(surge_fault_latch_n), .surge_fault_oe(surge_fault_oe),
  .supply_hold_n(supply_hold_n), .supply_hold_oe(supply_hold_oe),
  .kick_fault_n(kick_fault_n), .kick_fault_oe(kick_fault_oe));

//--- test/kick_host.sv
// host model: each strobe gives one 4-cycle low pulse, idle level is high
module kick_host (
  input wire logic clock,
  input wire logic strobe,
  output logic kick_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] low_q = 3'h0;  // cycles of low level left
  always @(posedge clock) begin
    if (strobe) begin
      low_q <= 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign kick_input = (low_q == 3'h0);
endmodule

//--- test/test_window_watchdog_supervisor.sv
// bench: options 0/0 keep the hold at 1 ms and the early limit at 1 ms
module test_window_watchdog_supervisor;
  import wwdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 100_000;  // 1 ms of cycles
  logic clock = 1'b0, rst_n = 1'b0, rail_over = 1'b0, rail_under = 1'b0;
  logic fault_wipe_n = 1'b1, strobe = 1'b0, kick_input;
  logic [OPT_W-1:0] win_sel = 4'h0, hold_sel = 4'h0;
  logic surge_n, surge_oe, hold_n, hold_oe, kick_n, kick_oe;
  int failures = 0, n_tests = 0;
  initial begin
    forever #5 clock = ~clock;
  end
  window_watchdog_supervisor u_window_watchdog_supervisor (.clock(clock), .rst_n(rst_n),
    .rail_over(rail_over), .rail_under(rail_under), .fault_wipe_n(fault_wipe_n),
    .kick_input(kick_input), .win_sel(win_sel), .hold_sel(hold_sel),
    .surge_fault_latch_n(surge_n), .surge_fault_oe(surge_oe), .supply_hold_n(hold_n),
    .supply_hold_oe(hold_oe), .kick_fault_n(kick_n), .kick_fault_oe(kick_oe));
  kick_host u_kick_host (.clock(clock), .strobe(strobe), .kick_input(kick_input));
  task automatic chk(input string what, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hold after reset lasts the selected time, not less
  task automatic t_reset();
    chk("surge", surge_n, 1'b1);
    chk("kick", kick_n, 1'b1);
    chk("hold", hold_n, 1'b0);
    chk("surge_oe", surge_oe, 1'b0);
    chk("hold_oe", hold_oe, 1'b1);
    chk("kick_oe", kick_oe, 1'b0);
    wait_n(HOLD - 10);
    chk("hold", hold_n, 1'b0);
    wait_n(30);
    chk("hold", hold_n, 1'b1);
    $display("test reset done");
  endtask
  // undervoltage holds the supply, release waits the hold time
  task automatic t_under();
    rail_under = 1'b1;
    wait_n(3);
    chk("hold", hold_n, 1'b0);
    rail_under = 1'b0;
    wait_n(HOLD - 10);
    chk("hold", hold_n, 1'b0);
    wait_n(30);
    chk("hold", hold_n, 1'b1);
    $display("test under done");
  endtask
  // surge latch: delay boundary, ignored wipe, short and long wipe
  task automatic t_surge();
    rail_over = 1'b1;
    wait_n(499);
    rail_over = 1'b0;
    wait_n(5);
    chk("surge", surge_n, 1'b1);
    rail_over = 1'b1;
    wait_n(495);
    chk("surge", surge_n, 1'b1);
    wait_n(10);
    chk("surge", surge_n, 1'b0);
    fault_wipe_n = 1'b0;
    wait_n(600);
    fault_wipe_n = 1'b1;
    rail_over = 1'b0;
    wait_n(3);
    chk("surge", surge_n, 1'b0);
    wait_n(HOLD + 20);
    chk("hold", hold_n, 1'b1);
    fault_wipe_n = 1'b0;
    wait_n(400);
    fault_wipe_n = 1'b1;
    wait_n(3);
    chk("surge", surge_n, 1'b0);
    fault_wipe_n = 1'b0;
    wait_n(510);
    chk("hold", hold_n, 1'b0);
    fault_wipe_n = 1'b1;
    wait_n(3);
    chk("surge", surge_n, 1'b1);
    wait_n(HOLD + 20);
    chk("hold", hold_n, 1'b1);
    $display("test surge done");
  endtask
  task automatic kick();
    strobe = 1'b1;
    wait_n(1);
    strobe = 1'b0;
  endtask
  // timing runs from the last hold release: two in-window kicks, then one far too early
  task automatic t_kick();
    wait_n(150_000);
    kick();
    wait_n(5);
    chk("kick", kick_n, 1'b1);
    wait_n(150_000);
    kick();
    wait_n(5);
    chk("kick", kick_n, 1'b1);
    wait_n(100);
    kick();
    wait_n(6);
    chk("kick", kick_n, 1'b0);
    $display("test kick done");
  endtask
  initial begin
    wait_n(4);
    rst_n = 1'b1;
    t_reset();
    t_under();
    t_surge();
    t_kick();
    close_out();
  end
  // whole run needs about 7.0 ms of simulated time
  initial begin
    #10_000_000;
    failures++;
    close_out();
  end
endmodule
